// file: common/ssfm_consts.svh
// Constants for the scan segment field monitor
`ifndef SSFM_CONSTS_SVH
`define SSFM_CONSTS_SVH
`define SSFM_SEGMENTS 529
`define SSFM_LAST_SEG 10'h210
`define SSFM_SWEEP_NS 40000000
`define SSFM_CLK_NS 10
`define SSFM_SWEEP_CYC (`SSFM_SWEEP_NS / `SSFM_CLK_NS)
`define SSFM_NEAR_MAX_MM 16'h7530
`define SSFM_FAR_MAX_MM 16'hC350
`define SSFM_FIFO_DEPTH 32
`define SSFM_DIST_W 16
`endif

// file: common/ssfm_pkg.sv
// Types for the scan segment field monitor
package ssfm_pkg;
   typedef enum logic [1:0] {
      SSFM_IDLE = 2'b00,
      SSFM_SCAN = 2'b01,
      SSFM_WAIT = 2'b10
   } ssfm_state_e;
   typedef enum logic [1:0] {
      SSFM_TX_IDLE = 2'b00,
      SSFM_TX_HI = 2'b01,
      SSFM_TX_LO = 2'b10
   } ssfm_tx_e;
endpackage

// file: rtl/ssfm_fifo.sv
// Synchronous valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module ssfm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Write side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Read side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } ssfm_fifo_s;
   ssfm_fifo_s st_q, st_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push, pop;
   assign in_ready_o = (st_q.cnt != DEPTH[AW:0]);
   assign out_valid_o = (st_q.cnt != '0);
   assign out_data_o = mem_q[st_q.rd];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wr = st_q.wr + 1'b1;
      end
      if (pop) begin
         st_d.rd = st_q.rd + 1'b1;
      end
      st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
      if (push) begin
         mem_q[st_q.wr] <= in_data_i;
      end
   end
endmodule // ssfm_fifo
`default_nettype wire

// file: rtl/ssfm_monitor.sv
// Scan sequencer, field evaluation and distance byte stream
`timescale 1ns/1ps
`default_nettype none
`include "ssfm_consts.svh"
module ssfm_monitor
   import ssfm_pkg::*;
#(
   parameter int SWEEP_CYC = `SSFM_SWEEP_CYC,
   parameter int FIFO_DEPTH = `SSFM_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Ranging front end
   output logic pulse_o,
   output logic [9:0] pulse_seg_o,
   input wire logic range_valid_i,
   input wire logic [15:0] range_mm_i,
   // Acquisition configuration
   input wire logic continuous_i,
   input wire logic single_req_i,
   input wire logic [9:0] win_start_i,
   input wire logic [9:0] win_stop_i,
   input wire logic [9:0] win_step_i,
   input wire logic cartesian_i,
   input wire logic [15:0] min_mm_i,
   input wire logic [15:0] max_mm_i,
   // Field contours, written over the config path while streaming
   input wire logic cfg_we_i,
   input wire logic [1:0] cfg_pair_i,
   input wire logic cfg_far_i,
   input wire logic [9:0] cfg_seg_i,
   input wire logic [15:0] cfg_mm_i,
   // Pair select, soiling and fault pins
   input wire logic pair_select_one_i,
   input wire logic pair_select_two_i,
   input wire logic pair_select_three_i,
   input wire logic pair_select_four_i,
   input wire logic soil_warn_i,
   input wire logic fault_i,
   // Switching outputs
   output logic near_shutdown_out_a_o,
   output logic near_shutdown_out_b_o,
   output logic far_warning_out_o,
   output logic fault_warning_out_o,
   // Host byte stream
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [7:0] tx_byte_o,
   output logic tx_cartesian_o,
   output logic sweep_busy_o
);
   localparam int SEGS = `SSFM_SEGMENTS;
   typedef struct packed {
      ssfm_state_e st;
      ssfm_tx_e tx;
      logic [31:0] tmr;
      logic [9:0] seg;
      logic [9:0] nxt_out;
      logic near_hit;
      logic far_hit;
      logic near_off;
      logic far_alarm;
      logic [1:0] pair;
      logic [5:0] pin1;
      logic [5:0] pin2;
      logic soil1, soil2, flt1, flt2;
      logic [7:0] lo;
      logic [7:0] hi_byte;
      logic tx_v;
   } ssfm_s;
   ssfm_s s_q, s_d;
   // Contours: index pair*2+far
   logic [15:0] cont_q [8][SEGS];
   logic [15:0] near_lim, far_lim;
   logic f_in_v, f_in_r, f_out_v, f_out_r;
   logic [15:0] f_out_d;
   logic in_win, in_lim, last_seg, sweep_end;
   logic [15:0] cfg_lim;
   ssfm_fifo #(.WIDTH(`SSFM_DIST_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .in_valid_i(f_in_v),
      .in_ready_o(f_in_r),
      .in_data_i(range_mm_i),
      .out_valid_o(f_out_v),
      .out_ready_i(f_out_r),
      .out_data_o(f_out_d)
   );
   assign near_lim = cont_q[{s_q.pair, 1'b0}][s_q.seg];
   assign far_lim = cont_q[{s_q.pair, 1'b1}][s_q.seg];
   assign last_seg = (s_q.seg == `SSFM_LAST_SEG);
   assign in_win = (s_q.seg >= win_start_i) && (s_q.seg <= win_stop_i)
      && (s_q.seg == s_q.nxt_out);
   assign in_lim = (range_mm_i >= min_mm_i) && (range_mm_i <= max_mm_i);
   assign f_in_v = (s_q.st == SSFM_SCAN) && range_valid_i && in_win && in_lim;
   assign f_out_r = (s_q.tx == SSFM_TX_IDLE);
   assign sweep_end = (s_q.st == SSFM_SCAN) && range_valid_i && last_seg;
   // Contour length clamped per field kind
   assign cfg_lim = cfg_far_i ? ((cfg_mm_i > `SSFM_FAR_MAX_MM) ? `SSFM_FAR_MAX_MM : cfg_mm_i)
      : ((cfg_mm_i > `SSFM_NEAR_MAX_MM) ? `SSFM_NEAR_MAX_MM : cfg_mm_i);
   always_ff @(posedge mclk_i) begin
      if (cfg_we_i && (cfg_seg_i <= `SSFM_LAST_SEG)) begin
         cont_q[{cfg_pair_i, cfg_far_i}][cfg_seg_i] <= cfg_lim;
      end
   end
   always_comb begin
      s_d = s_q;
      s_d.pin1 = {fault_i, soil_warn_i, pair_select_four_i, pair_select_three_i,
         pair_select_two_i, pair_select_one_i};
      s_d.pin2 = s_q.pin1;
      s_d.tmr = (s_q.tmr == 32'(SWEEP_CYC - 1)) ? 32'h0 : s_q.tmr + 32'h1;
      // One-hot pair select; other patterns keep the current pair
      unique case (s_q.pin2[3:0])
         4'h1: s_d.pair = 2'h0;
         4'h2: s_d.pair = 2'h1;
         4'h4: s_d.pair = 2'h2;
         4'h8: s_d.pair = 2'h3;
         default: s_d.pair = s_q.pair;
      endcase
      unique case (s_q.st)
         SSFM_IDLE: begin
            if ((continuous_i || single_req_i) && (s_q.tmr == 32'h0)) begin
               s_d.st = SSFM_SCAN;
               s_d.seg = 10'h0;
               s_d.nxt_out = win_start_i;
               s_d.near_hit = 1'b0;
               s_d.far_hit = 1'b0;
            end
         end
         SSFM_SCAN: begin
            if (range_valid_i) begin
               if (range_mm_i < near_lim) begin
                  s_d.near_hit = 1'b1;
               end
               if (range_mm_i < far_lim) begin
                  s_d.far_hit = 1'b1;
               end
               if (s_q.seg == s_q.nxt_out) begin
                  s_d.nxt_out = s_q.nxt_out + ((win_step_i == 10'h0) ? 10'h1 : win_step_i);
               end
               s_d.seg = s_q.seg + 10'h1;
               if (sweep_end) begin
                  s_d.st = SSFM_WAIT;
                  s_d.near_off = s_q.near_hit || (range_mm_i < near_lim);
                  s_d.far_alarm = s_q.far_hit || (range_mm_i < far_lim);
               end
            end
         end
         SSFM_WAIT: begin
            if (s_q.tmr != 32'h0) begin
               s_d.st = SSFM_IDLE;
            end
         end
         default: s_d.st = SSFM_IDLE;
      endcase
      unique case (s_q.tx)
         SSFM_TX_IDLE: begin
            if (f_out_v) begin
               s_d.hi_byte = f_out_d[15:8];
               s_d.lo = f_out_d[7:0];
               s_d.tx = SSFM_TX_HI;
               s_d.tx_v = 1'b1;
            end
         end
         SSFM_TX_HI: begin
            if (tx_ready_i) begin
               s_d.hi_byte = s_q.lo;
               s_d.tx = SSFM_TX_LO;
            end
         end
         SSFM_TX_LO: begin
            if (tx_ready_i) begin
               s_d.tx = SSFM_TX_IDLE;
               s_d.tx_v = 1'b0;
            end
         end
         default: s_d.tx = SSFM_TX_IDLE;
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign pulse_o = (s_q.st == SSFM_SCAN);
   assign pulse_seg_o = s_q.seg;
   assign near_shutdown_out_a_o = ~s_q.near_off;
   assign near_shutdown_out_b_o = ~s_q.near_off;
   assign far_warning_out_o = s_q.far_alarm || s_q.pin2[4];
   assign fault_warning_out_o = s_q.pin2[5];
   assign tx_valid_o = s_q.tx_v;
   assign tx_byte_o = s_q.hi_byte;
   assign tx_cartesian_o = cartesian_i;
   assign sweep_busy_o = (s_q.st == SSFM_SCAN) || f_out_v || s_q.tx_v;
endmodule // ssfm_monitor
`default_nettype wire

// file: tb/ssfm_chk_monitor.sv
// Checker bound to the scan segment field monitor
`timescale 1ns/1ps
`default_nettype none
module ssfm_chk #(
   parameter int SWEEP_CYC = 2000
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Watched ports
   input wire logic pulse_o,
   input wire logic [9:0] pulse_seg_o,
   input wire logic range_valid_i,
   input wire logic cartesian_i,
   input wire logic near_shutdown_out_a_o,
   input wire logic near_shutdown_out_b_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [7:0] tx_byte_o,
   input wire logic tx_cartesian_o
);
   int cnt_q;
   logic seen_q;
   logic take_w;
   assign take_w = pulse_o && range_valid_i;
   always_ff @(posedge mclk_i) begin
      cnt_q <= ($rose(pulse_o) || reset_i) ? 0 : cnt_q + 1;
      seen_q <= !reset_i && (seen_q || $rose(pulse_o));
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_near_twins: assert property (near_shutdown_out_a_o == near_shutdown_out_b_o)
      else $error("near outputs differ");
   a_seg_max: assert property (pulse_o |-> pulse_seg_o <= 10'h210)
      else $error("segment above last");
   a_seg_first: assert property ($rose(pulse_o) |-> pulse_seg_o == 10'h000)
      else $error("sweep not starting at segment zero");
   a_seg_step: assert property (take_w && pulse_seg_o != 10'h210 |=>
      pulse_seg_o == $past(pulse_seg_o) + 10'h001)
      else $error("segment did not advance by one");
   a_sweep_period: assert property ($rose(pulse_o) && seen_q |->
      cnt_q % SWEEP_CYC == SWEEP_CYC - 1)
      else $error("sweep start off period");
   a_byte_hold: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_byte_o))
      else $error("byte changed before acceptance");
   a_field_hold: assert property (!(take_w && pulse_seg_o == 10'h210) |=>
      $stable(near_shutdown_out_a_o))
      else $error("near output changed mid sweep");
   a_coord_tag: assert property (tx_cartesian_o == cartesian_i)
      else $error("coordinate tag wrong");
endmodule // ssfm_chk
bind ssfm_monitor ssfm_chk #(.SWEEP_CYC(SWEEP_CYC)) ssfm_chk_i (.mclk_i(mclk_i),
   .reset_i(reset_i),
   .pulse_o(pulse_o), .pulse_seg_o(pulse_seg_o), .range_valid_i(range_valid_i),
   .cartesian_i(cartesian_i), .near_shutdown_out_a_o(near_shutdown_out_a_o),
   .near_shutdown_out_b_o(near_shutdown_out_b_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .tx_byte_o(tx_byte_o), .tx_cartesian_o(tx_cartesian_o));
`default_nettype wire

// file: tb/ssfm_front.sv
// Ranging front end model answering each pulse
`timescale 1ns/1ps
`default_nettype none
module ssfm_front (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Pulse side
   input wire logic pulse_i,
   input wire logic [9:0] seg_i,
   input wire logic [15:0] obj_i,
   // Answer side
   output var logic valid_o = 1'b0,
   output var logic [15:0] mm_o = 16'h0000
);
   always_ff @(posedge mclk_i) begin
      valid_o <= 1'b0;
      mm_o <= ~mm_o;
      if (!reset_i && pulse_i && !valid_o) begin
         valid_o <= 1'b1;
         mm_o <= (seg_i == 10'h00F) ? obj_i : 16'h1000 + 16'(seg_i);
      end
   end
endmodule // ssfm_front
`default_nettype wire

// file: tb/ssfm_tb.sv
// Testbench for the scan segment field monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
   logic mclk_i = 1'b0, reset_i = 1'b1, pulse_o, range_valid_i, continuous_i = 1'b0;
   logic single_req_i = 1'b0, cartesian_i = 1'b0, cfg_we_i = 1'b0, cfg_far_i = 1'b0;
   logic [9:0] pulse_seg_o, win_start_i = 10'h00A, win_stop_i = 10'h014, win_step_i = 10'h002;
   logic [9:0] cfg_seg_i = 10'h000;
   logic [15:0] range_mm_i, min_mm_i = 16'h100C, max_mm_i = 16'h1012, cfg_mm_i = 16'h0000;
   logic [15:0] obj = 16'h100F;
   logic [1:0] cfg_pair_i = 2'h0;
   logic pair_select_one_i = 1'b1, pair_select_two_i = 1'b0, pair_select_three_i = 1'b0;
   logic pair_select_four_i = 1'b0, soil_warn_i = 1'b0, fault_i = 1'b0, tx_ready_i = 1'b0;
   logic near_shutdown_out_a_o, near_shutdown_out_b_o, far_warning_out_o, fault_warning_out_o;
   logic tx_valid_o, tx_cartesian_o, sweep_busy_o, seen;
   logic [7:0] tx_byte_o, b8;
   logic [7:0] q[$];
   int fails = 0, checks_done = 0;
   ssfm_monitor #(.SWEEP_CYC(2000), .FIFO_DEPTH(32)) ssfm_monitor_i (
      .mclk_i(mclk_i), .reset_i(reset_i), .pulse_o(pulse_o), .pulse_seg_o(pulse_seg_o),
      .range_valid_i(range_valid_i), .range_mm_i(range_mm_i), .continuous_i(continuous_i),
      .single_req_i(single_req_i), .win_start_i(win_start_i), .win_stop_i(win_stop_i),
      .win_step_i(win_step_i), .cartesian_i(cartesian_i), .min_mm_i(min_mm_i),
      .max_mm_i(max_mm_i), .cfg_we_i(cfg_we_i), .cfg_pair_i(cfg_pair_i), .cfg_far_i(cfg_far_i),
      .cfg_seg_i(cfg_seg_i), .cfg_mm_i(cfg_mm_i), .pair_select_one_i(pair_select_one_i),
      .pair_select_two_i(pair_select_two_i), .pair_select_three_i(pair_select_three_i),
      .pair_select_four_i(pair_select_four_i), .soil_warn_i(soil_warn_i), .fault_i(fault_i),
      .near_shutdown_out_a_o(near_shutdown_out_a_o),
      .near_shutdown_out_b_o(near_shutdown_out_b_o), .far_warning_out_o(far_warning_out_o),
      .fault_warning_out_o(fault_warning_out_o), .tx_valid_o(tx_valid_o),
      .tx_ready_i(tx_ready_i), .tx_byte_o(tx_byte_o), .tx_cartesian_o(tx_cartesian_o),
      .sweep_busy_o(sweep_busy_o));
   ssfm_front ssfm_front_i (.mclk_i(mclk_i), .reset_i(reset_i), .pulse_i(pulse_o),
      .seg_i(pulse_seg_o), .obj_i(obj), .valid_o(range_valid_i), .mm_o(range_mm_i));
   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      tx_ready_i <= ~tx_ready_i;
      if (tx_valid_o && tx_ready_i) q.push_back(tx_byte_o);
   end
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic sweep;
      int k;
      for (k = 0; k < 3000 && !pulse_o; k++) @(posedge mclk_i);
      `CHK("sweep_start", 1'b1, pulse_o)
      `CHK("busy", 1'b1, sweep_busy_o)
      single_req_i <= 1'b0;
      q.delete();
      for (k = 0; k < 3000 && pulse_o; k++) @(posedge mclk_i);
      repeat (40) @(posedge mclk_i);
   endtask
   task automatic stream(input int a, input int b, input int st);
      int s;
      logic [15:0] v;
      `CHK("count", 2 * ((b - a) / st + 1), q.size())
      for (s = a; s <= b && q.size() > 1; s += st) begin
         v = 16'h1000 + 16'(s);
         b8 = q.pop_front();
         `CHK("msb", v[15:8], b8)
         b8 = q.pop_front();
         `CHK("lsb", v[7:0], b8)
      end
   endtask
   task automatic pair(input int p, input logic n, input logic f);
      pair_select_one_i <= p == 0;
      pair_select_two_i <= p == 1;
      pair_select_three_i <= p == 2;
      pair_select_four_i <= p == 3;
      sweep;
      sweep;
      `CHK("near_a", n, near_shutdown_out_a_o)
      `CHK("near_b", n, near_shutdown_out_b_o)
      `CHK("far", f, far_warning_out_o)
      $display("test pair %0d done", p);
   endtask
   initial begin
      #600000;
      fails++;
      end_sim;
   end
   initial begin
      int i, c;
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      for (i = 0; i < 4232; i++) begin
         @(posedge mclk_i);
         c = i / 529;
         cfg_we_i <= 1'b1;
         cfg_pair_i <= 2'(c / 2);
         cfg_far_i <= c[0];
         cfg_seg_i <= 10'(i % 529);
         cfg_mm_i <= (i % 529 != 15) ? 16'h0000 : (c == 2 || c == 5) ? 16'h2000 :
            (c > 5) ? 16'hFFFF : 16'h0000;
      end
      @(posedge mclk_i);
      cfg_we_i <= 1'b0;
      continuous_i <= 1'b1;
      sweep;
      sweep;
      stream(12, 18, 2);
      $display("test stream done");
      pair(1, 1'b0, 1'b0);
      pair(2, 1'b1, 1'b1);
      obj <= 16'h7600;
      pair(3, 1'b1, 1'b1);
      obj <= 16'h100F;
      soil_warn_i <= 1'b1;
      pair(0, 1'b1, 1'b1);
      continuous_i <= 1'b0;
      cartesian_i <= 1'b1;
      win_start_i <= 10'h010;
      win_stop_i <= 10'h012;
      win_step_i <= 10'h000;
      min_mm_i <= 16'h0000;
      max_mm_i <= 16'hFFFF;
      single_req_i <= 1'b1;
      sweep;
      stream(16, 18, 1);
      `CHK("coord_tag", 1'b1, tx_cartesian_o)
      seen = 1'b0;
      repeat (2100) begin
         @(posedge mclk_i);
         seen = seen | pulse_o;
      end
      `CHK("no_resweep", 1'b0, seen)
      `CHK("busy_idle", 1'b0, sweep_busy_o)
      `CHK("fault_idle", 1'b0, fault_warning_out_o)
      fault_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      `CHK("fault", 1'b1, fault_warning_out_o)
      $display("test single done");
      end_sim;
   end
endmodule // testbench
`default_nettype wire
